// ==== audio_port_one_clocking.sv ====
// Bit-clock and frame-clock generation, channel and DSP path enables.
// Assumes an APB master on clk; link clock pins are sampled synchronously.
//
// Register access over APB is this design's own decision.
`default_nettype none

module audio_port_one_clocking #(
  parameter int NUM_CH = 6
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic audioCoreClockOn,
  input wire logic txFramePinSelected,
  input wire logic bitClockIn,
  output logic bitClockOut,
  output logic bitClockOe,
  input wire logic rxFrameIn,
  output logic rxFrameOut,
  output logic rxFrameOe,
  input wire logic txFrameIn,
  output logic txFrameOut,
  output logic txFrameOe,
  output logic txFrameSelected,
  output logic [NUM_CH-1:0] rxChanOn,
  output logic [NUM_CH-1:0] txChanOn,
  output logic dspLeftOutOn,
  output logic dspRightOutOn,
  output logic dspInputSource
);

  // Channel enables are one register field each; only six fit the design
  if (NUM_CH != 6) begin : g_num_ch_check
    $error("NUM_CH must be 6");
  end

  // Software registers
  logic [NUM_CH-1:0] rxChanOn_ff;
  logic [NUM_CH-1:0] txChanOn_ff;
  logic [1:0] dspOut_ff;
  logic dspSrc_ff;
  logic [10:0] bclkCtrl_ff; // Invert, force, master, divider code
  logic [10:0] txRate_ff;
  logic [10:0] rxRate_ff;
  logic [3:0] txFctrl_ff;
  logic [2:0] rxFctrl_ff;
  logic [31:0] prdata_ff;
  logic pready_ff;
  logic pslverr_ff;

  // Divider code to division ratio
  function automatic logic [6:0] divRatio(input logic [3:0] code);
    case (code)
      4'h0: divRatio = 7'h01;
      4'h1: divRatio = 7'h02;
      4'h2: divRatio = 7'h03;
      4'h3: divRatio = 7'h04;
      4'h4: divRatio = 7'h06;
      4'h5: divRatio = 7'h08;
      4'h6: divRatio = 7'h0c;
      4'h7: divRatio = 7'h10;
      4'h8: divRatio = 7'h18;
      4'h9: divRatio = 7'h20;
      4'ha: divRatio = 7'h30;
      4'hb: divRatio = 7'h40;
      default: divRatio = 7'h60;
    endcase
  endfunction

  // Rate below the minimum is clamped to keep frame timing sane
  function automatic logic [10:0] clampRate(input logic [10:0] r);
    clampRate = (r < audio_port_one_pkg::RATE_MIN) ? audio_port_one_pkg::RATE_MIN : r;
  endfunction

  // Address decode
  logic [9:0] idx;
  logic access;
  logic wrEn;
  logic mapped;
  assign idx = paddr[11:2];
  assign access = psel && penable && !pready_ff;
  assign wrEn = access && pwrite && mapped;
  always_comb begin
    case (idx)
      audio_port_one_pkg::IDX_DSP_OUT_EN, audio_port_one_pkg::IDX_TX_CH_EN,
      audio_port_one_pkg::IDX_DSP_IN_SRC, audio_port_one_pkg::IDX_BCLK_CTRL,
      audio_port_one_pkg::IDX_TX_RATE, audio_port_one_pkg::IDX_TX_FCTRL,
      audio_port_one_pkg::IDX_RX_RATE, audio_port_one_pkg::IDX_RX_FCTRL,
      audio_port_one_pkg::IDX_RX_CH_EN, audio_port_one_pkg::IDX_STATUS: mapped = 1'b1;
      default: mapped = 1'b0;
    endcase
  end

  // Register writes
  always_ff @(posedge clk) begin
    if (reset) begin
      rxChanOn_ff <= '0;
      txChanOn_ff <= '0;
      dspOut_ff <= 2'h0;
      dspSrc_ff <= 1'b0;
      bclkCtrl_ff <= 11'h000;
      txRate_ff <= audio_port_one_pkg::RATE_RESET;
      rxRate_ff <= audio_port_one_pkg::RATE_RESET;
      txFctrl_ff <= audio_port_one_pkg::TX_FCTRL_RESET;
      rxFctrl_ff <= 3'h0;
    end else if (wrEn) begin
      case (idx)
        audio_port_one_pkg::IDX_RX_CH_EN: rxChanOn_ff <= pwdata[NUM_CH-1:0];
        audio_port_one_pkg::IDX_TX_CH_EN: txChanOn_ff <= pwdata[NUM_CH-1:0];
        audio_port_one_pkg::IDX_DSP_OUT_EN: begin
          dspOut_ff <= {pwdata[audio_port_one_pkg::DSP_LEFT_BIT], pwdata[audio_port_one_pkg::DSP_RIGHT_BIT]};
        end
        audio_port_one_pkg::IDX_DSP_IN_SRC: dspSrc_ff <= pwdata[0];
        audio_port_one_pkg::IDX_BCLK_CTRL: begin
          bclkCtrl_ff <= {pwdata[audio_port_one_pkg::BCLK_INV_BIT:audio_port_one_pkg::BCLK_MSTR_BIT],
                          4'h0, pwdata[3:0]};
        end
        audio_port_one_pkg::IDX_TX_RATE: txRate_ff <= pwdata[10:0];
        audio_port_one_pkg::IDX_TX_FCTRL: txFctrl_ff <= pwdata[3:0];
        audio_port_one_pkg::IDX_RX_RATE: rxRate_ff <= pwdata[10:0];
        audio_port_one_pkg::IDX_RX_FCTRL: rxFctrl_ff <= pwdata[2:0];
        default: ;
      endcase
    end
  end

  // Field views
  logic bclkMaster;
  logic bclkForce;
  logic bclkInvert;
  logic anyChan;
  logic bclkOn;
  assign bclkMaster = bclkCtrl_ff[audio_port_one_pkg::BCLK_MSTR_BIT];
  assign bclkForce = bclkCtrl_ff[audio_port_one_pkg::BCLK_FRC_BIT];
  assign bclkInvert = bclkCtrl_ff[audio_port_one_pkg::BCLK_INV_BIT];
  assign anyChan = |rxChanOn_ff || |txChanOn_ff;
  // Driven when master with channels or when forced; never in plain slave
  assign bclkOn = bclkForce || (bclkMaster && anyChan);

  // Bit-clock generator on audio core clock; ratio latched at period ends
  audio_port_one_pkg::bclk_state_type bState_ff;
  logic [6:0] bCnt_ff;
  logic [6:0] bRatio_ff;
  logic bGen_ff;
  logic bRise;
  logic [6:0] halfHi;
  assign halfHi = bRatio_ff >> 1;
  always_ff @(posedge clk) begin
    if (reset) begin
      bState_ff <= audio_port_one_pkg::BCLK_IDLE;
      bCnt_ff <= 7'h00;
      bRatio_ff <= 7'h01;
      bGen_ff <= 1'b0;
    end else begin
      case (bState_ff)
        audio_port_one_pkg::BCLK_IDLE: begin
          bGen_ff <= 1'b0;
          if (audioCoreClockOn && bclkMaster) begin
            bRatio_ff <= divRatio(bclkCtrl_ff[3:0]);
            bCnt_ff <= 7'h00;
            bState_ff <= audio_port_one_pkg::BCLK_HIGH;
          end
        end
        audio_port_one_pkg::BCLK_HIGH, audio_port_one_pkg::BCLK_LOW: begin
          if (!audioCoreClockOn || !bclkMaster) begin
            bState_ff <= audio_port_one_pkg::BCLK_IDLE;
            bGen_ff <= 1'b0;
          end else if (bCnt_ff == bRatio_ff - 7'h01) begin
            // Period end: while running, take new ratio here only; idle exit also loads it
            bCnt_ff <= 7'h00;
            bRatio_ff <= divRatio(bclkCtrl_ff[3:0]);
            bGen_ff <= 1'b1;
            bState_ff <= audio_port_one_pkg::BCLK_HIGH;
          end else begin
            bCnt_ff <= bCnt_ff + 7'h01;
            if (bCnt_ff + 7'h01 >= halfHi && bRatio_ff != 7'h01) begin
              bGen_ff <= 1'b0;
              bState_ff <= audio_port_one_pkg::BCLK_LOW;
            end
          end
        end
        default: bState_ff <= audio_port_one_pkg::BCLK_IDLE;
      endcase
    end
  end

  // Source bit clock: internal when master, else pin; edge detect it
  logic bSrc;
  logic bSrcPrev_ff;
  assign bSrc = bclkMaster ? bGen_ff : bitClockIn;
  always_ff @(posedge clk) begin
    if (reset) bSrcPrev_ff <= 1'b0;
    else bSrcPrev_ff <= bSrc;
  end
  // Ratio 1 runs at clk rate; count every cycle then
  assign bRise = bclkMaster ? (bGen_ff && (!bSrcPrev_ff || bRatio_ff == 7'h01) &&
                               bState_ff != audio_port_one_pkg::BCLK_IDLE)
                            : (bSrc && !bSrcPrev_ff);

  // Frame dividers count bit-clock rising edges; rate taken at frame end
  logic [10:0] rxCnt_ff;
  logic [10:0] rxPer_ff;
  logic rxGen_ff;
  logic [10:0] txCnt_ff;
  logic [10:0] txPer_ff;
  logic txGen_ff;
  always_ff @(posedge clk) begin
    if (reset) begin
      rxCnt_ff <= 11'h000;
      rxPer_ff <= audio_port_one_pkg::RATE_RESET;
      rxGen_ff <= 1'b0;
    end else if (bRise) begin
      if (rxCnt_ff >= rxPer_ff - 11'h001) begin
        rxCnt_ff <= 11'h000;
        rxPer_ff <= clampRate(rxRate_ff);
        rxGen_ff <= 1'b1;
      end else begin
        rxCnt_ff <= rxCnt_ff + 11'h001;
        if (rxCnt_ff + 11'h001 == (rxPer_ff >> 1)) rxGen_ff <= 1'b0;
      end
    end
  end
  always_ff @(posedge clk) begin
    if (reset) begin
      txCnt_ff <= 11'h000;
      txPer_ff <= audio_port_one_pkg::RATE_RESET;
      txGen_ff <= 1'b0;
    end else if (bRise) begin
      if (txCnt_ff >= txPer_ff - 11'h001) begin
        txCnt_ff <= 11'h000;
        txPer_ff <= clampRate(txRate_ff);
        txGen_ff <= 1'b1;
      end else begin
        txCnt_ff <= txCnt_ff + 11'h001;
        if (txCnt_ff + 11'h001 == (txPer_ff >> 1)) txGen_ff <= 1'b0;
      end
    end
  end

  // Frame clock enables
  logic rxMaster;
  logic txMaster;
  logic separateTx;
  logic rxOn;
  logic txOn;
  logic bclkPresent;
  assign rxMaster = rxFctrl_ff[audio_port_one_pkg::FR_MSTR_BIT];
  assign txMaster = txFctrl_ff[audio_port_one_pkg::FR_MSTR_BIT];
  // Software must route the pin before the separate TX frame is used
  assign separateTx = !txFctrl_ff[audio_port_one_pkg::FR_MODE_BIT] && txFramePinSelected;
  assign bclkPresent = bclkMaster ? (bState_ff != audio_port_one_pkg::BCLK_IDLE) : 1'b1;
  assign rxOn = bclkPresent && (rxFctrl_ff[audio_port_one_pkg::FR_FRC_BIT] ||
                (rxMaster && (separateTx ? |rxChanOn_ff : anyChan)));
  assign txOn = bclkPresent && separateTx &&
                (txFctrl_ff[audio_port_one_pkg::FR_FRC_BIT] || (txMaster && |txChanOn_ff));

  // Registered pins and status
  always_ff @(posedge clk) begin
    if (reset) begin
      bitClockOut <= 1'b0;
      bitClockOe <= 1'b0;
      rxFrameOut <= 1'b0;
      rxFrameOe <= 1'b0;
      txFrameOut <= 1'b0;
      txFrameOe <= 1'b0;
      txFrameSelected <= 1'b0;
    end else begin
      bitClockOut <= bSrc ^ bclkInvert;
      bitClockOe <= bclkOn;
      rxFrameOut <= (rxMaster ? rxGen_ff : rxFrameIn) ^ rxFctrl_ff[audio_port_one_pkg::FR_INV_BIT];
      rxFrameOe <= rxOn;
      txFrameOut <= (txMaster ? txGen_ff : txFrameIn) ^ txFctrl_ff[audio_port_one_pkg::FR_INV_BIT];
      txFrameOe <= txOn;
      txFrameSelected <= separateTx;
    end
  end

  // Enable outputs straight from registers
  assign rxChanOn = rxChanOn_ff;
  assign txChanOn = txChanOn_ff;
  assign dspLeftOutOn = dspOut_ff[1];
  assign dspRightOutOn = dspOut_ff[0];
  assign dspInputSource = dspSrc_ff;

  // APB read and answer, one wait state
  always_ff @(posedge clk) begin
    if (reset) begin
      prdata_ff <= 32'h0;
      pready_ff <= 1'b0;
      pslverr_ff <= 1'b0;
    end else begin
      pready_ff <= access;
      pslverr_ff <= access && !mapped;
      prdata_ff <= 32'h0;
      if (access && !pwrite) begin
        case (idx)
          audio_port_one_pkg::IDX_RX_CH_EN: prdata_ff <= {26'h0, rxChanOn_ff};
          audio_port_one_pkg::IDX_TX_CH_EN: prdata_ff <= {26'h0, txChanOn_ff};
          audio_port_one_pkg::IDX_DSP_OUT_EN: prdata_ff <= {22'h0, dspOut_ff, 8'h0};
          audio_port_one_pkg::IDX_DSP_IN_SRC: prdata_ff <= {31'h0, dspSrc_ff};
          audio_port_one_pkg::IDX_BCLK_CTRL: prdata_ff <= {21'h0, bclkCtrl_ff};
          audio_port_one_pkg::IDX_TX_RATE: prdata_ff <= {21'h0, txRate_ff};
          audio_port_one_pkg::IDX_TX_FCTRL: prdata_ff <= {28'h0, txFctrl_ff};
          audio_port_one_pkg::IDX_RX_RATE: prdata_ff <= {21'h0, rxRate_ff};
          audio_port_one_pkg::IDX_RX_FCTRL: prdata_ff <= {29'h0, rxFctrl_ff};
          audio_port_one_pkg::IDX_STATUS: prdata_ff <= {26'h0, txOn, rxOn, bclkOn, bclkPresent, bState_ff};
          default: prdata_ff <= 32'h0;
        endcase
      end
    end
  end
  assign prdata = prdata_ff;
  assign pready = pready_ff;
  assign pslverr = pslverr_ff;

endmodule

`default_nettype wire

// ==== audio_port_one_clocking_monitor.sv ====
// Checker for the audio port one clocking block, on its ports only.
// Assumes one clock domain and the bind at the foot of this file.
`default_nettype none
module audio_port_one_clocking_monitor #(
  parameter int NUM_CH = 6
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic bitClockOe,
  input wire logic [NUM_CH-1:0] rxChanOn,
  input wire logic [NUM_CH-1:0] txChanOn,
  input wire logic dspLeftOutOn,
  input wire logic dspRightOutOn,
  input wire logic dspInputSource
);
  timeunit 1ns;
  timeprecision 1ns;
  // One domain; reset cancels every check but the reset one
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);
  // Access phase still waiting for its answer
  sequence s_take;
    psel && penable && !pready;
  endsequence
  // Write taken at one register index
  sequence s_wr(idx);
    s_take ##0 (pwrite && paddr[11:2] == idx);
  endsequence
  property p_reset;
    disable iff (1'b0) reset |=> rxChanOn == '0 && txChanOn == '0 && !dspLeftOutOn && !dspRightOutOn
      && !dspInputSource && !bitClockOe;
  endproperty
  property p_answer;
    s_take |=> pready ##1 !pready;
  endproperty
  property p_refused;
    pready && pslverr && !pwrite |-> prdata == 32'h0;
  endproperty
  property p_rx_wr;
    s_wr(audio_port_one_pkg::IDX_RX_CH_EN) |=> rxChanOn == $past(pwdata[NUM_CH-1:0]);
  endproperty
  property p_tx_wr;
    s_wr(audio_port_one_pkg::IDX_TX_CH_EN) |=> txChanOn == $past(pwdata[NUM_CH-1:0]);
  endproperty
  property p_dsp_wr;
    s_wr(audio_port_one_pkg::IDX_DSP_OUT_EN) |=> {dspLeftOutOn, dspRightOutOn} == $past(pwdata[9:8]);
  endproperty
  property p_src_wr;
    s_wr(audio_port_one_pkg::IDX_DSP_IN_SRC) |=> dspInputSource == $past(pwdata[0]);
  endproperty
  property p_hold;
    !(psel && penable && pwrite) |=> $stable(rxChanOn) && $stable(txChanOn);
  endproperty
  a_reset: assert property (p_reset) else $error("enables not clear after reset");
  a_answer: assert property (p_answer) else $error("bus answer late or too long");
  a_refused: assert property (p_refused) else $error("refused read returned data");
  a_rx_wr: assert property (p_rx_wr) else $error("rx channel enables wrong");
  a_tx_wr: assert property (p_tx_wr) else $error("tx channel enables wrong");
  a_dsp_wr: assert property (p_dsp_wr) else $error("dsp output enables wrong");
  a_src_wr: assert property (p_src_wr) else $error("dsp input source wrong");
  a_hold: assert property (p_hold) else $error("channel enables moved without write");
endmodule
bind audio_port_one_clocking audio_port_one_clocking_monitor #(.NUM_CH(NUM_CH)) monitor_inst (.*);
`default_nettype wire

// ==== audio_port_one_clocking_tb.sv ====
// Self-checking bench for the audio port one clocking block.
// Assumes the monitor bind and the far-side model are compiled first.
`default_nettype none
module audio_port_one_clocking_tb;
  timeunit 1ns;
  timeprecision 1ns;
  typedef struct {logic [9:0] idx; logic [31:0] wd; logic [14:0] port;} row_type;
  logic clk, reset, psel, penable, pwrite, audioCoreClockOn, txFramePinSelected, farRun, er;
  logic [31:0] paddr, pwdata, prdata, rd;
  logic pready, pslverr, bitClockOut, bitClockOe, rxFrameOut, rxFrameOe, txFrameOut, txFrameOe;
  logic txFrameSelected, dspLeftOutOn, dspRightOutOn, dspInputSource, farBit, farFrame;
  logic [5:0] rxChanOn, txChanOn;
  wire logic bitClockIn, rxFrameIn, txFrameIn;
  int n_errors, total_checks, p;
  // Rows: register, value written, enables expected {src,left,right,tx,rx}
  row_type rows[9] = '{'{10'h004, 32'h3f, 15'h003f}, '{10'h006, 32'h2a, 15'h0abf},
    '{10'h005, 32'h200, 15'h2abf}, '{10'h005, 32'h100, 15'h1abf}, '{10'h008, 32'h1, 15'h5abf},
    '{10'h004, 32'h0, 15'h5a80}, '{10'h006, 32'h15, 15'h5540}, '{10'h008, 32'h0, 15'h1540},
    '{10'h302, 32'h7ff, 15'h1540}};
  int ratio[16] = '{1, 2, 3, 4, 6, 8, 12, 16, 24, 32, 48, 64, 96, 96, 96, 96};
  // Pin levels: the design wins while it drives
  assign bitClockIn = bitClockOe ? bitClockOut : farBit;
  assign rxFrameIn = rxFrameOe ? rxFrameOut : farFrame;
  assign txFrameIn = txFrameOe ? txFrameOut : farFrame;
  audio_port_one_clocking audio_port_one_clocking_inst (.*);
  far_side_model far_side_model_inst (.clk(clk), .run(farRun), .bitClk(farBit), .frameClk(farFrame));
  // 25 MHz clock
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  // Report, verdict and end of run
  task automatic wrap_up();
    $display("checks %0d errors %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  // Compare one value
  task automatic chk(input string nm, input logic [31:0] ex, input logic [31:0] got);
    total_checks++;
    if (got !== ex) begin
      $display("MISMATCH %s expected %h seen %h", nm, ex, got);
      n_errors++;
    end
  endtask
  // One bus transfer, entered just after a rising edge
  task automatic apb(input logic w, input logic [9:0] idx, input logic [31:0] d);
    int n;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= {20'h0, idx, 2'b00};
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (pready !== 1'b1) begin
      chk("bus answer", 32'h1, 32'h0);
      wrap_up();
    end
    @(posedge clk);
  endtask
  // Period in cycles between rising edges of the bit or rx frame clock
  task automatic per(input bit f);
    int n, r, t0;
    logic s, prv;
    r = 0;
    t0 = 0;
    prv = 1'b1;
    p = 0;
    for (n = 0; n < 2000 && r < 3; n++) begin
      @(posedge clk);
      s = f ? rxFrameOut : bitClockOut;
      if (s === 1'b1 && prv === 1'b0) begin
        r++;
        if (r == 3) p = n - t0;
        t0 = n;
      end
      prv = s;
    end
    if (r < 3) begin
      chk("clock edges", 32'd3, r);
      wrap_up();
    end
  endtask
  // Main sequence
  initial begin
    reset <= 1'b1;
    psel <= 1'b0;
    penable <= 1'b0;
    pwrite <= 1'b0;
    paddr <= 32'h0;
    pwdata <= 32'h0;
    audioCoreClockOn <= 1'b0;
    txFramePinSelected <= 1'b0;
    farRun <= 1'b0;
    n_errors = 0;
    total_checks = 0;
    repeat (4) @(posedge clk);
    reset <= 1'b0;
    @(posedge clk);
    chk("enables at reset", 32'h0, {dspInputSource, dspLeftOutOn, dspRightOutOn, txChanOn, rxChanOn});
    apb(1'b0, audio_port_one_pkg::IDX_RX_RATE, 32'h0);
    chk("rx rate reset", 32'h80, rd);
    apb(1'b0, audio_port_one_pkg::IDX_TX_RATE, 32'h0);
    chk("tx rate reset", 32'h80, rd);
    apb(1'b0, audio_port_one_pkg::IDX_TX_FCTRL, 32'h0);
    chk("tx frame control reset", 32'h8, rd);
    foreach (rows[i]) begin
      apb(1'b1, rows[i].idx, rows[i].wd);
      apb(1'b0, rows[i].idx, 32'h0);
      chk("readback", rows[i].wd, rd);
      chk("path enables", rows[i].port, {dspInputSource, dspLeftOutOn, dspRightOutOn, txChanOn, rxChanOn});
    end
    // Unmapped place refuses both directions
    apb(1'b1, 10'h3ff, 32'h1);
    chk("unmapped write error", 32'h1, er);
    apb(1'b0, 10'h3ff, 32'h0);
    chk("unmapped read data", 32'h0, rd);
    chk("unmapped read error", 32'h1, er);
    // Slave: pins left to the far side until forced
    farRun <= 1'b1;
    chk("slave enables", 32'h0, {bitClockOe, rxFrameOe});
    apb(1'b1, audio_port_one_pkg::IDX_BCLK_CTRL, 32'h200);
    apb(1'b1, audio_port_one_pkg::IDX_RX_FCTRL, 32'h2);
    repeat (4) @(posedge clk);
    chk("forced enables", 32'h3, {bitClockOe, rxFrameOe});
    // Master: divider codes 1 to 15
    audioCoreClockOn <= 1'b1;
    for (int c = 1; c < 16; c++) begin
      apb(1'b1, audio_port_one_pkg::IDX_BCLK_CTRL, 32'h100 | c);
      per(1'b0);
      chk("bit clock period", ratio[c], p);
    end
    chk("master bit clock drive", 32'h1, bitClockOe);
    apb(1'b1, audio_port_one_pkg::IDX_BCLK_CTRL, 32'h101);
    apb(1'b1, audio_port_one_pkg::IDX_RX_RATE, 32'h8);
    apb(1'b1, audio_port_one_pkg::IDX_RX_FCTRL, 32'h1);
    per(1'b1);
    chk("rx frame period", 32'd16, p);
    chk("rx frame drive", 32'h1, rxFrameOe);
    // Code zero holds the bit clock high; invert flips the pin level
    apb(1'b1, audio_port_one_pkg::IDX_BCLK_CTRL, 32'h100);
    repeat (4) @(posedge clk);
    chk("bit clock code zero", 32'h1, bitClockOut);
    apb(1'b1, audio_port_one_pkg::IDX_BCLK_CTRL, 32'h500);
    repeat (4) @(posedge clk);
    chk("bit clock inverted", 32'h0, bitClockOut);
    // Separate tx frame clock, master
    txFramePinSelected <= 1'b1;
    apb(1'b1, audio_port_one_pkg::IDX_TX_FCTRL, 32'h1);
    repeat (4) @(posedge clk);
    chk("tx frame selected", 32'h3, {txFrameSelected, txFrameOe});
    chk("rx frame with split tx", 32'h0, rxFrameOe);
    // All channels off, nothing forced: no clocks driven
    apb(1'b1, audio_port_one_pkg::IDX_TX_CH_EN, 32'h0);
    repeat (4) @(posedge clk);
    chk("idle enables", 32'h0, {bitClockOe, rxFrameOe, txFrameOe});
    // Reset in mid-run returns every setting to its default
    reset <= 1'b1;
    repeat (2) @(posedge clk);
    reset <= 1'b0;
    @(posedge clk);
    chk("enables after reset", 32'h0, {bitClockOe, dspInputSource, dspLeftOutOn, dspRightOutOn, txChanOn, rxChanOn});
    apb(1'b0, audio_port_one_pkg::IDX_RX_RATE, 32'h0);
    chk("rx rate after reset", 32'h80, rd);
    wrap_up();
  end
endmodule
`default_nettype wire

// ==== audio_port_one_pkg.sv ====
// Package for the audio port one clocking and path-enable block.
// Assumes an APB slave with 32-bit data; register indexes are word indexes.
`default_nettype none

package audio_port_one_pkg;
  // Register indexes (byte address is four times the index)
  localparam logic [9:0] IDX_DSP_OUT_EN = 10'h005;
  localparam logic [9:0] IDX_TX_CH_EN = 10'h006;
  localparam logic [9:0] IDX_DSP_IN_SRC = 10'h008;
  localparam logic [9:0] IDX_BCLK_CTRL = 10'h301;
  localparam logic [9:0] IDX_TX_RATE = 10'h302;
  localparam logic [9:0] IDX_TX_FCTRL = 10'h303;
  localparam logic [9:0] IDX_RX_RATE = 10'h304;
  localparam logic [9:0] IDX_RX_FCTRL = 10'h305;
  localparam logic [9:0] IDX_RX_CH_EN = 10'h004;
  localparam logic [9:0] IDX_STATUS = 10'h310;
  // Field positions
  localparam int DSP_LEFT_BIT = 9;
  localparam int DSP_RIGHT_BIT = 8;
  localparam int BCLK_INV_BIT = 10;
  localparam int BCLK_FRC_BIT = 9;
  localparam int BCLK_MSTR_BIT = 8;
  localparam int FR_MODE_BIT = 3;
  localparam int FR_INV_BIT = 2;
  localparam int FR_FRC_BIT = 1;
  localparam int FR_MSTR_BIT = 0;
  // Reset values and minimum rate
  localparam logic [10:0] RATE_RESET = 11'h080;
  localparam logic [10:0] RATE_MIN = 11'h008;
  localparam logic [3:0] TX_FCTRL_RESET = 4'h8;
  // Divider code decode
  localparam logic [3:0] DIV_LAST_CODE = 4'hc;
  // Bit-clock generator states
  typedef enum logic [1:0] {
    BCLK_IDLE = 2'b00,
    BCLK_HIGH = 2'b01,
    BCLK_LOW = 2'b11
  } bclk_state_type;
endpackage

`default_nettype wire

// ==== far_side_model.sv ====
// Far-side audio device: makes bit and frame clocks while the port is slave.
// Assumes the bench resolves each pin against the design's output enable.
`default_nettype none
module far_side_model (
  input wire logic clk,
  input wire logic run,
  output logic bitClk,
  output logic frameClk
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [3:0] bitCnt; // Bit clock rises within a frame
  // Bit clock at half of clk, frame every 16 bits; still when idle
  always_ff @(posedge clk) begin
    if (!run) begin
      bitClk <= 1'b0;
      bitCnt <= 4'h0;
    end else begin
      bitClk <= ~bitClk;
      if (!bitClk) begin
        bitCnt <= bitCnt + 4'h1;
      end
    end
  end
  assign frameClk = bitCnt[3];
endmodule
`default_nettype wire
